// ### logic/rlr_pkg.sv
/*
  Constants, encodings and register map of the rotate unit.
  Assumes one T-state per clock of the CPU clock.
*/
package rlr_pkg;

  // Opcode bytes
  localparam logic [7:0] OPC_ACC_RLC = 8'h07;
  localparam logic [7:0] OPC_ACC_RL  = 8'h17;
  localparam logic [7:0] OPC_ACC_RRC = 8'h0f;
  localparam logic [7:0] OPC_ACC_RR  = 8'h1f;
  localparam logic [7:0] PFX_BIT     = 8'hcb;
  localparam logic [7:0] PFX_IDX1    = 8'hdd;
  localparam logic [7:0] PFX_IDX2    = 8'hfd;
  localparam logic [7:0] OPC_MEM_RLC = 8'h06;

  // Register select codes of the prefixed form
  localparam logic [2:0] REG_MEM_CODE = 3'h6;
  localparam logic [2:0] REG_A        = 3'h7;

  // Flag bit positions
  localparam int FLG_S  = 7;
  localparam int FLG_Z  = 6;
  localparam int FLG_H  = 4;
  localparam int FLG_PV = 2;
  localparam int FLG_N  = 1;
  localparam int FLG_C  = 0;

  // T-states per machine cycle kind
  localparam logic [2:0] TS_FETCH  = 3'h4;
  localparam logic [2:0] TS_DISP   = 3'h3;
  localparam logic [2:0] TS_IDX_OP = 3'h5;
  localparam logic [2:0] TS_MEM_RD = 3'h4;
  localparam logic [2:0] TS_MEM_WR = 3'h3;

  // APB byte offsets
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_ACC_F  = 8'h08;
  localparam logic [7:0] ADDR_BCDE   = 8'h0c;
  localparam logic [7:0] ADDR_PTR    = 8'h10;
  localparam logic [7:0] ADDR_IDX1   = 8'h14;
  localparam logic [7:0] ADDR_IDX2   = 8'h18;
  localparam logic [7:0] ADDR_PC     = 8'h1c;

  // Control and status fields
  localparam int CTRL_RUN_BIT   = 0;
  localparam int CTRL_ERR_BIT   = 1;
  localparam int STAT_T_LSB     = 0;
  localparam int STAT_M_LSB     = 8;
  localparam int STAT_ERR_BIT   = 12;
  localparam int STAT_BUSY_BIT  = 13;

  // Values after reset
  localparam logic [7:0]  REG_RST = 8'h00;
  localparam logic [7:0]  FLG_RST = 8'h00;
  localparam logic [15:0] PC_RST  = 16'h0000;
  localparam logic [15:0] IDX_RST = 16'h0000;

  typedef enum logic [2:0] {
    OP_RLCA = 3'b000,
    OP_RLA  = 3'b001,
    OP_ACC_ROTATE_RIGHT_CIRCULAR = 3'b010,
    OP_RRA  = 3'b011,
    OP_RLC  = 3'b100
  } rlr_op_e;

  typedef enum logic [2:0] {
    ST_IDLE     = 3'b000,
    ST_FETCH    = 3'b001,
    ST_CB_OP    = 3'b010,
    ST_IDX_CB   = 3'b011,
    ST_IDX_DISP = 3'b100,
    ST_IDX_OP   = 3'b101,
    ST_MEM_RD   = 3'b110,
    ST_MEM_WR   = 3'b111
  } rlr_state_e;

endpackage : rlr_pkg

// ### logic/rlr_rot_alu.sv
/*
  Combinational rotate datapath with flag update.
  Assumes the caller holds operand and old flags stable for the cycle used.
*/
`timescale 1ns/100ps
`default_nettype none
module rlr_rot_alu
  import rlr_pkg::*;
(
  input  wire rlr_op_e    op_i,     // Rotate kind
  input  wire logic [7:0] data_i,   // Operand byte
  input  wire logic [7:0] flags_i,  // Flags before
  output logic      [7:0] res_o,    // Rotated byte
  output logic      [7:0] flags_o   // Flags after
);

  always_comb begin
    res_o   = data_i;
    flags_o = flags_i;
    unique case (op_i)
      OP_RLCA: begin
        res_o          = {data_i[6:0], data_i[7]};
        flags_o[FLG_C] = data_i[7];
      end
      OP_RLA: begin
        res_o          = {data_i[6:0], flags_i[FLG_C]}; // [RQ1]
        flags_o[FLG_C] = data_i[7];                     // [RQ1]
      end
      OP_ACC_ROTATE_RIGHT_CIRCULAR: begin
        res_o          = {data_i[0], data_i[7:1]};      // [RQ12]
        flags_o[FLG_C] = data_i[0];                     // [RQ3]
      end
      OP_RRA: begin
        res_o          = {flags_i[FLG_C], data_i[7:1]}; // [RQ2]
        flags_o[FLG_C] = data_i[0];                     // [RQ3]
      end
      OP_RLC: begin
        res_o           = {data_i[6:0], data_i[7]};     // [RQ6]
        flags_o[FLG_C]  = data_i[7];                    // [RQ6]
        flags_o[FLG_S]  = data_i[6];                    // [RQ7]
        flags_o[FLG_Z]  = (data_i == 8'h00);            // [RQ7]
        flags_o[FLG_PV] = ~^data_i;                     // [RQ7]
      end
      default: begin
        res_o = data_i;
      end
    endcase
    // S, Z and P/V stay for accumulator forms; H and N always clear
    flags_o[FLG_H] = 1'b0; // [RQ4] [RQ7]
    flags_o[FLG_N] = 1'b0; // [RQ4] [RQ7]
  end

endmodule : rlr_rot_alu
`default_nettype wire

// ### logic/rlr_mcycle_timer.sv
/*
  Machine-cycle timer: counts down the T-states of the current cycle.
  Assumes load_i is only raised while last_o is high.
*/
`timescale 1ns/100ps
`default_nettype none
module rlr_mcycle_timer
  import rlr_pkg::*;
(
  input  wire logic       mclk_i,   // CPU clock, one T-state
  input  wire logic       rst_b_i,  // Async reset, active low
  input  wire logic       load_i,   // Start a new machine cycle
  input  wire logic [2:0] len_i,    // T-states of that cycle
  output logic            last_o    // Final T-state of cycle
);

  logic [2:0] cnt_reg;

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_reg <= 3'h0;
    end else if (load_i) begin
      cnt_reg <= len_i - 3'h1;
    end else if (cnt_reg != 3'h0) begin
      cnt_reg <= cnt_reg - 3'h1;
    end
  end

  assign last_o = (cnt_reg == 3'h0);

endmodule : rlr_mcycle_timer
`default_nettype wire

// ### logic/rlr_unit.sv
/*
  Rotate unit: fetches and executes the accumulator rotates and the
  prefixed circular left rotate on a register, on memory at the pointer
  pair, or on memory at an index register plus displacement.
  Assumes a memory that returns read data by the last T-state of a read
  cycle and takes write data during the write cycle; APB slave for
  software access to registers and control.
*/
// Function
// [RQ1] Opcode 17 rotates A left through carry
// [RQ2] Right through carry: old carry into bit7
// [RQ3] Both accumulator right rotates: carry gets bit0
// [RQ4] Accumulator rotates keep S Z PV, clear H N
// [RQ5] CB then 00000rrr rotates selected register
// [RQ6] Circular left: bit7 to carry and bit0
// [RQ7] Prefixed form sets S Z parity, clears H N
// [RQ8] CB 06 rotates memory at pointer pair
// [RQ9] DD CB d 06 uses first index plus d
// [RQ10] FD CB d 06 uses second index plus d
// [RQ11] Indexed form takes 4,4,3,5,4,3 T-states
// [RQ12] Circular right copies bit0; accumulator forms 4T
`timescale 1ns/100ps
`default_nettype none
module rlr_unit
  import rlr_pkg::*;
(
  input  wire logic        mclk_i,       // CPU clock, 10 MHz
  input  wire logic        rst_b_i,      // Async reset, active low
  input  wire logic        psel_i,       // APB select
  input  wire logic        penable_i,    // APB enable
  input  wire logic        pwrite_i,     // APB direction
  input  wire logic [7:0]  paddr_i,      // APB byte address
  input  wire logic [31:0] pwdata_i,     // APB write data
  output logic      [31:0] prdata_o,     // APB read data
  output logic             pready_o,     // APB ready
  output logic             pslverr_o,    // APB error
  input  wire logic [7:0]  mem_rdata_i,  // Memory read data
  output logic      [15:0] mem_addr_o,   // Memory address
  output logic             mem_rd_o,     // Read cycle level
  output logic             mem_wr_o,     // Write cycle level
  output logic      [7:0]  mem_wdata_o,  // Memory write data
  output logic             done_o        // Instruction end pulse
);

  rlr_state_e  st_reg;
  rlr_state_e  st_next;
  logic [7:0]  regs_reg [0:7];
  logic [7:0]  flags_reg;
  logic [15:0] pc_reg;
  logic [15:0] idx1_reg;
  logic [15:0] idx2_reg;
  logic        use_idx2_reg;
  logic [7:0]  disp_reg;
  logic [7:0]  op2_reg;
  logic        run_reg;
  logic        err_reg;
  logic [2:0]  m_acc_reg;
  logic [4:0]  t_acc_reg;
  logic [2:0]  last_m_reg;
  logic [4:0]  last_t_reg;
  logic [15:0] mem_addr_reg;
  logic        mem_rd_reg;
  logic        mem_wr_reg;
  logic [7:0]  mem_wdata_reg;
  logic        done_reg;
  logic [31:0] prdata_reg;
  logic        pready_reg;
  logic        pslverr_reg;

  logic        mlast;
  logic        tload;
  logic [2:0]  len_next;
  logic [15:0] addr_next;
  logic        rd_next;
  logic        wr_next;
  logic        pc_inc;
  logic        fin;
  logic        unsup;
  logic        acc_exec;
  logic        reg_exec;
  logic        mem_exec;
  logic        disp_ld;
  logic        idx_ld;
  logic        idx_sel;
  rlr_op_e     alu_op;
  logic [7:0]  alu_in;
  logic [7:0]  alu_res;
  logic [7:0]  alu_flags;
  logic [15:0] ptr_pair;
  logic [15:0] idx_addr;
  logic        apb_setup;
  logic        apb_wr;
  logic [31:0] rd_mux;
  logic        addr_ok;

  assign ptr_pair = {regs_reg[4], regs_reg[5]};
  assign idx_addr = (use_idx2_reg ? idx2_reg : idx1_reg)
                  + {{8{disp_reg[7]}}, disp_reg};

  rlr_mcycle_timer u_timer (
    .mclk_i  (mclk_i),
    .rst_b_i (rst_b_i),
    .load_i  (tload),
    .len_i   (len_next),
    .last_o  (mlast)
  );

  rlr_rot_alu u_alu (
    .op_i    (alu_op),
    .data_i  (alu_in),
    .flags_i (flags_reg),
    .res_o   (alu_res),
    .flags_o (alu_flags)
  );

  // Sequencer: chooses the next machine cycle at the last T-state
  always_comb begin
    st_next   = st_reg;
    len_next  = TS_FETCH;
    addr_next = pc_reg;
    rd_next   = 1'b1;
    wr_next   = 1'b0;
    pc_inc    = 1'b0;
    fin       = 1'b0;
    unsup     = 1'b0;
    acc_exec  = 1'b0;
    reg_exec  = 1'b0;
    mem_exec  = 1'b0;
    disp_ld   = 1'b0;
    idx_ld    = 1'b0;
    idx_sel   = 1'b0;
    alu_op    = OP_RLC;
    alu_in    = mem_rdata_i;
    unique case (st_reg)
      ST_IDLE: begin
        if (run_reg) begin
          st_next = ST_FETCH;
        end else begin
          rd_next = 1'b0;
        end
      end
      ST_FETCH: begin
        pc_inc = 1'b1;
        alu_in = regs_reg[REG_A];
        if (mem_rdata_i == OPC_ACC_RLC) begin
          alu_op   = OP_RLCA;
          acc_exec = 1'b1;
        end else if (mem_rdata_i == OPC_ACC_RL) begin
          alu_op   = OP_RLA;                     // [RQ1]
          acc_exec = 1'b1;
        end else if (mem_rdata_i == OPC_ACC_RRC) begin
          alu_op   = OP_ACC_ROTATE_RIGHT_CIRCULAR;                    // [RQ3]
          acc_exec = 1'b1;
        end else if (mem_rdata_i == OPC_ACC_RR) begin
          alu_op   = OP_RRA;                     // [RQ2]
          acc_exec = 1'b1;
        end else if (mem_rdata_i == PFX_BIT) begin
          st_next = ST_CB_OP;
        end else if (mem_rdata_i == PFX_IDX1) begin
          st_next = ST_IDX_CB;                   // [RQ9]
          idx_ld  = 1'b1;
        end else if (mem_rdata_i == PFX_IDX2) begin
          st_next = ST_IDX_CB;                   // [RQ10]
          idx_ld  = 1'b1;
          idx_sel = 1'b1;
        end else begin
          unsup = 1'b1;
        end
        fin = acc_exec;                          // [RQ12]
      end
      ST_CB_OP: begin
        pc_inc = 1'b1;
        alu_in = regs_reg[mem_rdata_i[2:0]];
        if (mem_rdata_i == OPC_MEM_RLC) begin
          st_next   = ST_MEM_RD;                 // [RQ8]
          len_next  = TS_MEM_RD;
          addr_next = ptr_pair;                  // [RQ8]
        end else if (mem_rdata_i[7:3] == 5'h00) begin
          reg_exec = 1'b1;                       // [RQ5]
          fin      = 1'b1;
        end else begin
          unsup = 1'b1;
        end
      end
      ST_IDX_CB: begin
        pc_inc = 1'b1;
        if (mem_rdata_i == PFX_BIT) begin
          st_next  = ST_IDX_DISP;
          len_next = TS_DISP;                    // [RQ11]
        end else begin
          unsup = 1'b1;
        end
      end
      ST_IDX_DISP: begin
        pc_inc   = 1'b1;
        disp_ld  = 1'b1;
        st_next  = ST_IDX_OP;
        len_next = TS_IDX_OP;                    // [RQ11]
      end
      ST_IDX_OP: begin
        pc_inc = 1'b1;
        if (mem_rdata_i == OPC_MEM_RLC) begin
          st_next   = ST_MEM_RD;
          len_next  = TS_MEM_RD;                 // [RQ11]
          addr_next = idx_addr;                  // [RQ9] [RQ10]
        end else begin
          unsup = 1'b1;
        end
      end
      ST_MEM_RD: begin
        mem_exec  = 1'b1;
        st_next   = ST_MEM_WR;
        len_next  = TS_MEM_WR;                   // [RQ11]
        addr_next = mem_addr_reg;                // [RQ8]
        rd_next   = 1'b0;
        wr_next   = 1'b1;
      end
      ST_MEM_WR: begin
        fin = 1'b1;
      end
    endcase
    // After an instruction, fetch again only while running
    if (fin) begin
      st_next   = run_reg ? ST_FETCH : ST_IDLE;
      len_next  = TS_FETCH;
      addr_next = pc_inc ? pc_reg + 16'h0001 : pc_reg;
      rd_next   = run_reg;
      wr_next   = 1'b0;
    end else if (pc_inc && st_next != ST_MEM_RD) begin
      addr_next = pc_reg + 16'h0001;
    end
    if (unsup) begin
      st_next = ST_IDLE;
      rd_next = 1'b0;
      wr_next = 1'b0;
    end
  end

  assign tload = mlast && (st_next != ST_IDLE);

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_reg <= ST_IDLE;
    end else if (mlast) begin
      st_reg <= st_next;
    end
  end

  // Memory cycle outputs, held for a whole machine cycle
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mem_addr_reg  <= 16'h0000;
      mem_rd_reg    <= 1'b0;
      mem_wr_reg    <= 1'b0;
      mem_wdata_reg <= 8'h00;
    end else if (mlast) begin
      mem_addr_reg <= addr_next;
      mem_rd_reg   <= rd_next;
      mem_wr_reg   <= wr_next;
      if (mem_exec) begin
        mem_wdata_reg <= alu_res;               // [RQ8]
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      disp_reg     <= 8'h00;
      use_idx2_reg <= 1'b0;
      op2_reg      <= 8'h00;
    end else if (mlast) begin
      if (disp_ld) begin
        disp_reg <= mem_rdata_i;                // [RQ9]
      end
      if (idx_ld) begin
        use_idx2_reg <= idx_sel;                // [RQ10]
      end
      if (st_reg == ST_CB_OP) begin
        op2_reg <= mem_rdata_i;
      end
    end
  end

  // Register file, flags and pointers; the core wins over software
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      for (int i = 0; i < 8; i++) begin
        regs_reg[i] <= REG_RST;
      end
      flags_reg <= FLG_RST;
      pc_reg    <= PC_RST;
      idx1_reg  <= IDX_RST;
      idx2_reg  <= IDX_RST;
    end else begin
      if (apb_wr) begin
        unique case (paddr_i)
          ADDR_ACC_F: begin
            regs_reg[REG_A] <= pwdata_i[7:0];
            flags_reg       <= pwdata_i[15:8];
          end
          ADDR_BCDE: begin
            regs_reg[0] <= pwdata_i[31:24];
            regs_reg[1] <= pwdata_i[23:16];
            regs_reg[2] <= pwdata_i[15:8];
            regs_reg[3] <= pwdata_i[7:0];
          end
          ADDR_PTR: begin
            regs_reg[4] <= pwdata_i[15:8];
            regs_reg[5] <= pwdata_i[7:0];
          end
          ADDR_IDX1: idx1_reg <= pwdata_i[15:0];
          ADDR_IDX2: idx2_reg <= pwdata_i[15:0];
          ADDR_PC:   pc_reg   <= pwdata_i[15:0];
          default: begin
          end
        endcase
      end
      if (mlast) begin
        if (pc_inc) begin
          pc_reg <= pc_reg + 16'h0001;
        end
        if (acc_exec) begin
          regs_reg[REG_A] <= alu_res;           // [RQ1] [RQ2] [RQ12]
          flags_reg       <= alu_flags;         // [RQ4]
        end
        if (reg_exec) begin
          regs_reg[mem_rdata_i[2:0]] <= alu_res; // [RQ5] [RQ6]
          flags_reg                  <= alu_flags; // [RQ7]
        end
        if (mem_exec) begin
          flags_reg <= alu_flags;               // [RQ7]
        end
      end
    end
  end

  // Run control; a stop on a foreign opcode beats a software start
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      run_reg <= 1'b0;
      err_reg <= 1'b0;
    end else begin
      if (apb_wr && paddr_i == ADDR_CTRL) begin
        run_reg <= pwdata_i[CTRL_RUN_BIT];
        if (pwdata_i[CTRL_ERR_BIT]) begin
          err_reg <= 1'b0;
        end
      end
      if (mlast && unsup) begin
        run_reg <= 1'b0;
        err_reg <= 1'b1;
      end
    end
  end

  // Cycle accounting of the instruction just finished
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      m_acc_reg  <= 3'h0;
      t_acc_reg  <= 5'h00;
      last_m_reg <= 3'h0;
      last_t_reg <= 5'h00;
      done_reg   <= 1'b0;
    end else begin
      done_reg <= mlast && fin && !unsup;
      if (st_reg == ST_IDLE || (mlast && (fin || unsup))) begin
        m_acc_reg <= 3'h0;
        t_acc_reg <= 5'h00;
      end else begin
        t_acc_reg <= t_acc_reg + 5'h01;
        if (mlast) begin
          m_acc_reg <= m_acc_reg + 3'h1;
        end
      end
      if (st_reg != ST_IDLE && mlast && fin) begin
        last_m_reg <= m_acc_reg + 3'h1;         // [RQ11]
        last_t_reg <= t_acc_reg + 5'h01;        // [RQ11]
      end
    end
  end

  // APB slave, zero wait states; read data is captured in the setup cycle
  assign apb_setup = psel_i && !penable_i && !pready_reg;
  assign apb_wr    = psel_i && penable_i && pwrite_i && pready_reg;

  always_comb begin
    rd_mux  = 32'h0000_0000;
    addr_ok = 1'b1;
    unique case (paddr_i)
      ADDR_CTRL:   rd_mux[CTRL_RUN_BIT] = run_reg;
      ADDR_STATUS: begin
        rd_mux[STAT_T_LSB +: 5]  = last_t_reg;
        rd_mux[STAT_M_LSB +: 3]  = last_m_reg;
        rd_mux[STAT_ERR_BIT]     = err_reg;
        rd_mux[STAT_BUSY_BIT]    = (st_reg != ST_IDLE);
      end
      ADDR_ACC_F:  rd_mux[15:0] = {flags_reg, regs_reg[REG_A]};
      ADDR_BCDE:   rd_mux = {regs_reg[0], regs_reg[1],
                             regs_reg[2], regs_reg[3]};
      ADDR_PTR:    rd_mux[15:0] = ptr_pair;
      ADDR_IDX1:   rd_mux[15:0] = idx1_reg;
      ADDR_IDX2:   rd_mux[15:0] = idx2_reg;
      ADDR_PC:     rd_mux[15:0] = pc_reg;
      default:     addr_ok = 1'b0;
    endcase
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      prdata_reg  <= 32'h0000_0000;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end else if (apb_setup) begin
      prdata_reg  <= pwrite_i ? 32'h0000_0000 : rd_mux;
      pready_reg  <= 1'b1;
      pslverr_reg <= !addr_ok;
    end else begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end
  end

  assign prdata_o    = prdata_reg;
  assign pready_o    = pready_reg;
  assign pslverr_o   = pslverr_reg;
  assign mem_addr_o  = mem_addr_reg;
  assign mem_rd_o    = mem_rd_reg;
  assign mem_wr_o    = mem_wr_reg;
  assign mem_wdata_o = mem_wdata_reg;
  assign done_o      = done_reg;

endmodule : rlr_unit
`default_nettype wire

// ### verif/rlr_mem_model.sv
/*
  Memory holding program and operands, facing the rotate unit.
  Assumes the unit holds address and strobes through each cycle.
*/
`timescale 1ns/100ps
`default_nettype none
module rlr_mem_model (
  input  wire logic [15:0] addr_i,   // Address
  input  wire logic        mclk_i,   // Clock
  input  wire logic        rd_i,     // Read level
  input  wire logic        wr_i,     // Write level
  input  wire logic [7:0]  wdata_i,  // Write data
  output logic      [7:0]  rdata_o   // Read data
);
  logic [7:0] mem [0:65535];
  logic [7:0] junk_q = 8'h00;

  // Outside reads the bus moves every cycle, so a late sample shows up
  assign rdata_o = rd_i ? mem[addr_i] : junk_q;

  always @(posedge mclk_i) begin
    junk_q <= junk_q + 8'h3b;
    if (wr_i)
      mem[addr_i] <= wdata_i;
  end
endmodule : rlr_mem_model
`default_nettype wire

// ### verif/rlr_unit_asserts.sv
/*
  Port checker of the rotate unit.
  Assumes it is bound to rlr_unit and sees only its ports.
*/
`timescale 1ns/100ps
`default_nettype none
module rlr_unit_asserts (
  input wire logic        mclk_i,       // Clock
  input wire logic        rst_b_i,      // Reset
  input wire logic        psel_i,       // APB
  input wire logic        penable_i,    // APB
  input wire logic        pwrite_i,     // APB
  input wire logic [7:0]  paddr_i,      // APB
  input wire logic [31:0] pwdata_i,     // APB
  input wire logic [31:0] prdata_o,     // APB
  input wire logic        pready_o,     // APB
  input wire logic        pslverr_o,    // APB
  input wire logic [7:0]  mem_rdata_i,  // Memory
  input wire logic [15:0] mem_addr_o,   // Memory
  input wire logic        mem_rd_o,     // Memory
  input wire logic        mem_wr_o,     // Memory
  input wire logic [7:0]  mem_wdata_o,  // Memory
  input wire logic        done_o        // End pulse
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_b_i);

  sequence s_setup;
    psel_i && !penable_i;
  endsequence
  sequence s_wr_cycle;
    mem_wr_o [*3] ##1 !mem_wr_o;
  endsequence

  chk_apb_ready: assert property (s_setup |=> pready_o ##1 !pready_o)
    else $error("ready not one cycle after setup");
  chk_bad_addr: assert property (pready_o && !pwrite_i
    && (paddr_i > 8'h1c || paddr_i[1:0] != 2'h0)
    |-> pslverr_o && prdata_o == 32'h0)
    else $error("unmapped read not refused");
  chk_good_addr: assert property (pready_o && paddr_i <= 8'h1c
    && paddr_i[1:0] == 2'h0 |-> !pslverr_o)
    else $error("mapped access refused");
  chk_wr_len: assert property ($rose(mem_wr_o) |-> s_wr_cycle)
    else $error("write cycle not three states");
  chk_wr_addr: assert property ($rose(mem_wr_o) |->
    ($past(mem_rd_o) && mem_addr_o == $past(mem_addr_o))
    ##1 $stable(mem_addr_o) [*2])
    else $error("write address differs from read");
  chk_wr_rot: assert property ($rose(mem_wr_o) |->
    mem_wdata_o == {$past(mem_rdata_i[6:0]), $past(mem_rdata_i[7])})
    else $error("written byte not rotated read byte");
  chk_wr_done: assert property ($fell(mem_wr_o) |-> done_o)
    else $error("no end pulse after write cycle");
  chk_rd_wr_excl: assert property (!(mem_rd_o && mem_wr_o))
    else $error("read and write together");
endmodule : rlr_unit_asserts

bind rlr_unit rlr_unit_asserts chk_u (.mclk_i, .rst_b_i, .psel_i,
  .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o,
  .pslverr_o, .mem_rdata_i, .mem_addr_o, .mem_rd_o, .mem_wr_o,
  .mem_wdata_o, .done_o);
`default_nettype wire

// ### verif/rlr_unit_tb.sv
/*
  Self-checking bench of the rotate unit: APB master and scenarios.
  Assumes the memory model beside the unit and the bound checker.
*/
`timescale 1ns/100ps
`default_nettype none
module rlr_unit_tb
  import rlr_pkg::*;
;
  logic        mclk_i    = 1'b0;
  logic        rst_b_i   = 1'b0;
  logic        psel_i    = 1'b0;
  logic        penable_i = 1'b0;
  logic        pwrite_i  = 1'b0;
  logic [7:0]  paddr_i   = 8'h00;
  logic [31:0] pwdata_i  = 32'h0;
  logic [31:0] prdata_o;
  logic        pready_o;
  logic        pslverr_o;
  logic [7:0]  mem_rdata_i;
  logic [15:0] mem_addr_o;
  logic        mem_rd_o;
  logic        mem_wr_o;
  logic [7:0]  mem_wdata_o;
  logic        done_o;
  logic [31:0] rd;
  logic        err;
  int          miscompares = 0;
  int          n_checks    = 0;
  int          n_done      = 0;

  always #50 mclk_i = ~mclk_i;

  rlr_unit dut_u (.mclk_i, .rst_b_i, .psel_i, .penable_i, .pwrite_i,
    .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .mem_rdata_i,
    .mem_addr_o, .mem_rd_o, .mem_wr_o, .mem_wdata_o, .done_o);
  rlr_mem_model mem_u (.addr_i(mem_addr_o), .mclk_i, .rd_i(mem_rd_o),
    .wr_i(mem_wr_o), .wdata_i(mem_wdata_o), .rdata_o(mem_rdata_i));

  always @(posedge mclk_i)
    if (done_o === 1'b1)
      n_done <= n_done + 1;

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop

  task automatic chk(input string nm, input logic [31:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int i;
    @(posedge mclk_i);
    psel_i   <= 1'b1;
    pwrite_i <= w;
    paddr_i  <= a;
    pwdata_i <= d;
    @(posedge mclk_i);
    penable_i <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge mclk_i);
      if (pready_o === 1'b1)
        break;
    end
    if (i == 20) begin
      miscompares++;
      report_and_stop();
    end
    rd = prdata_o;
    err = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb

  // Starts one instruction at 0x100; clearing run lets only it finish
  task automatic run(input logic [7:0] b0, b1, b2, b3);
    int n0;
    int i;
    mem_u.mem[16'h0100] = b0;
    mem_u.mem[16'h0101] = b1;
    mem_u.mem[16'h0102] = b2;
    mem_u.mem[16'h0103] = b3;
    apb(1'b1, ADDR_PC, 32'h100);
    n0 = n_done;
    apb(1'b1, ADDR_CTRL, 32'h1);
    apb(1'b1, ADDR_CTRL, 32'h0);
    for (i = 0; i < 60 && n_done == n0; i++)
      @(posedge mclk_i);
    if (n_done == n0) begin
      miscompares++;
      report_and_stop();
    end
  endtask : run

  task automatic chk_time(input logic [2:0] m, input logic [4:0] t);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("m-cycles", {29'h0, rd[10:8]}, {29'h0, m});
    chk("t-states", {27'h0, rd[4:0]}, {27'h0, t});
    chk("error", {31'h0, rd[12]}, 32'h0);
  endtask : chk_time

  function automatic logic [7:0] f_pfx(input logic [7:0] v, f);
    logic [7:0] r;
    r = {v[6:0], v[7]};
    return {r[7], r == 8'h00, f[5], 1'b0, f[3], ~^r, 1'b0, v[7]};
  endfunction : f_pfx

  task automatic t_regs;
    apb(1'b0, ADDR_ACC_F, 32'h0);
    chk("acc_f reset", rd, 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped err", {31'h0, err}, 32'h1);
    chk("unmapped data", rd, 32'h0);
    apb(1'b1, ADDR_IDX1, 32'h1234);
    apb(1'b0, ADDR_IDX1, 32'h0);
    chk("first index", rd, 32'h1234);
    $display("test regs done");
  endtask : t_regs

  // Case: opcode, A before, A after, carry in, carry out
  task automatic t_acc;
    logic [31:0] tc [4] = '{32'h1776ed10, 32'h1fe1f011,
                            32'h0f319801, 32'h07881101};
    logic [31:0] v;
    for (int k = 0; k < 4; k++) begin
      v = tc[k];
      apb(1'b1, ADDR_ACC_F, {16'h0, 8'hfe | {7'h0, v[4]}, v[23:16]});
      run(v[31:24], 8'h00, 8'h00, 8'h00);
      apb(1'b0, ADDR_ACC_F, 32'h0);
      chk("acc", {24'h0, rd[7:0]}, {24'h0, v[15:8]});
      chk("flags", {24'h0, rd[15:8]}, {24'h0, 7'h76, v[0]});
      chk_time(3'h1, 5'h04);
    end
    $display("test acc done");
  endtask : t_acc

  task automatic t_cb_reg;
    logic [7:0] ini [8] = '{8'h88, 8'h01, 8'h00, 8'h80,
                           8'h7f, 8'h96, 8'h00, 8'hc3};
    logic [7:0] e [8];
    for (int r = 0; r < 8; r++) begin
      if (r == 6)
        continue;
      e = ini;
      e[r] = {ini[r][6:0], ini[r][7]};
      apb(1'b1, ADDR_BCDE, {ini[0], ini[1], ini[2], ini[3]});
      apb(1'b1, ADDR_PTR, {16'h0, ini[4], ini[5]});
      apb(1'b1, ADDR_ACC_F, {24'h0, ini[7]});
      run(PFX_BIT, {5'h0, r[2:0]}, 8'h00, 8'h00);
      apb(1'b0, ADDR_BCDE, 32'h0);
      chk("bcde", rd, {e[0], e[1], e[2], e[3]});
      apb(1'b0, ADDR_PTR, 32'h0);
      chk("ptr", rd, {16'h0, e[4], e[5]});
      apb(1'b0, ADDR_ACC_F, 32'h0);
      chk("af", rd, {16'h0, f_pfx(ini[r], 8'h00), e[7]});
      chk_time(3'h2, 5'h08);
    end
    $display("test cb reg done");
  endtask : t_cb_reg

  task automatic t_mem;
    logic [7:0]  pf [3] = '{8'h00, PFX_IDX1, PFX_IDX2};
    logic [7:0]  dd [3] = '{8'h00, 8'h02, 8'hfe};
    logic [15:0] ad [3] = '{16'h2828, 16'h1002, 16'h1ffe};
    logic [7:0]  dv [3] = '{8'h88, 8'h00, 8'h80};
    apb(1'b1, ADDR_PTR, 32'h2828);
    apb(1'b1, ADDR_IDX1, 32'h1000);
    apb(1'b1, ADDR_IDX2, 32'h2000);
    for (int k = 0; k < 3; k++) begin
      mem_u.mem[ad[k]] = dv[k];
      apb(1'b1, ADDR_ACC_F, 32'hff00);
      if (k == 0)
        run(PFX_BIT, OPC_MEM_RLC, 8'h00, 8'h00);
      else
        run(pf[k], PFX_BIT, dd[k], OPC_MEM_RLC);
      chk("mem", {24'h0, mem_u.mem[ad[k]]},
          {24'h0, dv[k][6:0], dv[k][7]});
      apb(1'b0, ADDR_ACC_F, 32'h0);
      chk("flags", {24'h0, rd[15:8]},
          {24'h0, f_pfx(dv[k], 8'hff)});
      if (k == 0)
        chk_time(3'h4, 5'h0f);
      else
        chk_time(3'h6, 5'h17);
    end
    $display("test mem done");
  endtask : t_mem

  initial begin
    repeat (5) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    t_regs();
    t_acc();
    t_cb_reg();
    t_mem();
    report_and_stop();
  end
endmodule : rlr_unit_tb
`default_nettype wire
